// File: sync_serial_port_pkg.sv
// Types and constants shared by the synchronous serial port files.
// Assumes a SystemVerilog-2012 tool flow; imported by the compander and port files, not the FIFO.
package sync_serial_port_pkg;
    localparam int WORD_W = 32;
    localparam int FIFO_DEPTH = 16;
    localparam int LINES = 2;
    localparam logic [5:0] LEN_MIN_STD = 6'h03;
    localparam logic [5:0] LEN_MIN_AUD = 6'h08;
    localparam logic [5:0] LEN_MAX = 6'h20;
    // Half period of two core cycles caps the bit rate at a quarter of it
    localparam logic [7:0] HALF_DIV_MIN = 8'h02;
    localparam logic [15:0] MU_BIAS = 16'h0084;
    localparam logic [15:0] MU_CLIP = 16'h7f7b;
    localparam logic [7:0] A_INV_MASK = 8'h55;
    localparam logic [12:0] A_CLIP = 13'h0fff;

    typedef enum logic [2:0] {
        FRM_STD = 3'h0,
        FRM_TDM = 3'h1,
        FRM_I2S = 3'h2,
        FRM_PI2S = 3'h3,
        FRM_LJ = 3'h4
    } frame_mode_t;

    typedef enum logic [1:0] {
        CMP_NONE = 2'h0,
        CMP_MU = 2'h1,
        CMP_A = 2'h2
    } compand_t;

    typedef struct packed {
        frame_mode_t mode;
        logic msb_first;
        logic [5:0] word_len;
        logic [6:0] slots_m1;
        logic [11:0] frame_bits;
        logic [7:0] clk_half;
        logic int_clk;
        logic int_fs;
        logic [1:0] line_tx;
        logic [1:0][1:0] compand;
        logic pair_en;
        logic pair_rx;
    } cfg_t;

    typedef struct packed {
        logic fs;
        logic [1:0] dat;
    } pins_t;

    typedef struct packed {
        logic fs_err;
        logic [1:0] overrun;
        logic [1:0] underrun;
    } status_t;
endpackage

// File: sync_serial_fifo.sv
// Word FIFO with valid/ready on both sides.
// Assumes one clock; the reader may stall so the buffer can fill.
`timescale 1ns/1ns
`default_nettype none
module sync_serial_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } fifo_t;
    fifo_t fifo_ff, nxt_fifo;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    assign in_ready_o = (fifo_ff.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (fifo_ff.cnt != '0);
    assign out_data_o = mem[fifo_ff.rd];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always_comb begin
        nxt_fifo = fifo_ff;
        if (push) begin
            nxt_fifo.wr = fifo_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_fifo.rd = fifo_ff.rd + 1'b1;
        end
        nxt_fifo.cnt = fifo_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fifo_ff <= '0;
        end else begin
            fifo_ff <= nxt_fifo;
        end
    end

    // Storage needs no reset; only counted words are ever read
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[fifo_ff.wr] <= in_data_i;
        end
    end

    a_fifo_full_stall: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (fifo_ff.cnt == (AW+1)'(DEPTH) && !out_ready_i) |=> (fifo_ff.cnt == (AW+1)'(DEPTH)))
        else $error("fifo lost its full state");
endmodule
`default_nettype wire

// File: sync_serial_compand.sv
// Per-line mu-law / A-law compressor and expander, purely combinational.
// Assumes 16-bit signed linear samples in the low bits of a word.
`timescale 1ns/1ns
`default_nettype none
module sync_serial_compand (
    input wire logic [1:0] mode_i,
    input wire logic compress_i,
    input wire logic [31:0] din_i,
    output logic [31:0] dout_o
);
    import sync_serial_port_pkg::*;

    function automatic logic [7:0] mu_enc(logic [15:0] x);
        logic [15:0] mag;
        logic [2:0] e;
        mag = x[15] ? 16'(-x) : x;
        mag = ((mag > MU_CLIP) ? MU_CLIP : mag) + MU_BIAS;
        e = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (mag[i+7]) e = 3'(i);
        end
        return ~{x[15], e, 4'(mag >> (4'(e) + 4'h3))};
    endfunction

    function automatic logic [15:0] mu_dec(logic [7:0] c);
        logic [7:0] k;
        logic [15:0] mag;
        k = ~c;
        mag = 16'((({12'h000, k[3:0]} << 3) + MU_BIAS) << k[6:4]) - MU_BIAS;
        return k[7] ? 16'(-mag) : mag;
    endfunction

    function automatic logic [7:0] a_enc(logic [15:0] x);
        logic [15:0] abs16;
        logic [12:0] mag;
        logic [2:0] e;
        abs16 = x[15] ? 16'(-x) : x;
        mag = abs16[15:3];
        mag = mag[12] ? A_CLIP : mag;
        e = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (mag[i+4]) e = 3'(i);
        end
        return {~x[15], e, (e == 3'h0) ? mag[4:1] : 4'(mag >> e)} ^ A_INV_MASK;
    endfunction

    function automatic logic [15:0] a_dec(logic [7:0] c);
        logic [7:0] k;
        logic [15:0] mag;
        k = c ^ A_INV_MASK;
        mag = {8'h00, k[3:0], 4'h8};
        if (k[6:4] != 3'h0) mag = 16'((mag + 16'h0100) << (k[6:4] - 3'h1));
        return k[7] ? mag : 16'(-mag);
    endfunction

    always_comb begin
        dout_o = din_i;
        if (mode_i == CMP_MU) begin
            dout_o = compress_i ? {24'h000000, mu_enc(din_i[15:0])} :
                                  32'(signed'(mu_dec(din_i[7:0])));
        end else if (mode_i == CMP_A) begin
            dout_o = compress_i ? {24'h000000, a_enc(din_i[15:0])} :
                                  32'(signed'(a_dec(din_i[7:0])));
        end
    end
endmodule
`default_nettype wire

// File: sync_serial_port.sv
// One synchronous serial port: clock/frame-sync engine, two data lines,
// per-line word FIFO and companding, sticky error status.
// Assumes sclk_clk_i is the port clock pin (looped back from sclk_o when
// the clock is made here); cfg_i changes only while en_i is low.
`timescale 1ns/1ns
`default_nettype none
module sync_serial_port (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic sclk_clk_i,
    input wire logic en_i,
    input wire sync_serial_port_pkg::cfg_t cfg_i,
    input wire sync_serial_port_pkg::status_t err_clr_i,
    input wire logic err_chain_i,
    output sync_serial_port_pkg::status_t status_o,
    output logic err_irq_o,
    output logic sclk_o,
    output logic sclk_oe_o,
    input wire sync_serial_port_pkg::pins_t pin_in_i,
    output sync_serial_port_pkg::pins_t pin_out_o,
    output sync_serial_port_pkg::pins_t pin_oe_o,
    input wire logic [1:0] dma_tx_valid_i,
    output logic [1:0] dma_tx_ready_o,
    input wire logic [1:0][31:0] dma_tx_data_i,
    output logic [1:0] dma_rx_valid_o,
    input wire logic [1:0] dma_rx_ready_i,
    output logic [1:0][31:0] dma_rx_data_o
);
    import sync_serial_port_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] w_s;
        logic w_seen;
        logic [2:0] e_s;
        logic e_seen;
        logic [7:0] div_cnt;
        logic sclk;
        logic sclk_oe;
        logic [1:0][31:0] tx_hold;
        logic [1:0] tx_full;
        status_t st;
        logic irq;
    } core_t;

    typedef struct packed {
        logic [2:0] en_s;
        logic on;
        cfg_t cfg;
        logic fs_pin;
        logic fs_d;
        logic fs_gen;
        logic [11:0] fcnt;
        logic pend;
        logic busy;
        logic [5:0] idx;
        logic [6:0] left;
        logic [1:0][31:0] tx_sh;
        logic [1:0][31:0] rx_sh;
        logic [1:0][31:0] rx_hold;
        logic [1:0] dout;
        logic word_tgl;
        logic ev_rx;
        logic ev_tx;
        logic err_tgl;
    } link_t;

    core_t core_ff, nxt_core;
    link_t link_ff, nxt_link;

    logic word_evt, err_evt;
    logic [1:0] txm, int_sel;
    logic [7:0] half;
    logic [1:0] fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [1:0][31:0] fifo_in_data, fifo_out_data, cmp_in, cmp_out;
    logic fs_now, pulse_mode, delay_mode, start_evt, start, last, cont;
    logic ev_rx, ev_tx;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [5:0] eff_len(cfg_t k);
        logic [5:0] lo;
        lo = (k.mode == FRM_I2S || k.mode == FRM_LJ) ? LEN_MIN_AUD : LEN_MIN_STD;
        if (k.word_len < lo) return lo;
        if (k.word_len > LEN_MAX) return LEN_MAX;
        return k.word_len;
    endfunction

    // Pairing forces line roles and hands clock/fs to the tx partner
    function automatic logic [1:0] eff_tx(cfg_t k);
        return k.pair_en ? {2{~k.pair_rx}} : k.line_tx;
    endfunction

    function automatic logic [1:0] eff_int(cfg_t k);
        return {k.int_clk, k.int_fs} & {2{~(k.pair_en & k.pair_rx)}};
    endfunction

    function automatic logic [4:0] bit_pos(logic [5:0] i, logic [5:0] len, logic msb);
        return msb ? 5'(len - 6'h01 - i) : 5'(i);
    endfunction

    // ------------------------------------------------------------
    // Per-line buffering and companding
    // ------------------------------------------------------------
    for (genvar g = 0; g < LINES; g++) begin : g_line
        sync_serial_fifo #(
            .WIDTH(WORD_W),
            .DEPTH(FIFO_DEPTH)
        ) u_fifo (
            .core_clk_i(core_clk_i),
            .rst_b_i(rst_b_i),
            .in_valid_i(fifo_in_valid[g]),
            .in_ready_o(fifo_in_ready[g]),
            .in_data_i(fifo_in_data[g]),
            .out_valid_o(fifo_out_valid[g]),
            .out_ready_i(fifo_out_ready[g]),
            .out_data_o(fifo_out_data[g])
        );
        sync_serial_compand u_cmp (
            .mode_i(cfg_i.compand[g]),
            .compress_i(txm[g]),
            .din_i(cmp_in[g]),
            .dout_o(cmp_out[g])
        );
    end

    // ------------------------------------------------------------
    // Core domain
    // ------------------------------------------------------------
    assign txm = eff_tx(cfg_i);
    assign int_sel = eff_int(cfg_i);
    assign half = (cfg_i.clk_half < HALF_DIV_MIN) ? HALF_DIV_MIN : cfg_i.clk_half;
    // Link words are held stable between toggles, so they are read here
    assign word_evt = (core_ff.w_s[2] == core_ff.w_s[1]) && (core_ff.w_s[2] != core_ff.w_seen);
    assign err_evt = (core_ff.e_s[2] == core_ff.e_s[1]) && (core_ff.e_s[2] != core_ff.e_seen);

    always_comb begin
        nxt_core = core_ff;
        nxt_core.w_s = {core_ff.w_s[1:0], link_ff.word_tgl};
        nxt_core.e_s = {core_ff.e_s[1:0], link_ff.err_tgl};
        if (word_evt) begin
            nxt_core.w_seen = core_ff.w_s[2];
        end
        if (err_evt) begin
            nxt_core.e_seen = core_ff.e_s[2];
        end
        if (en_i && int_sel[1]) begin
            if (core_ff.div_cnt >= half - 8'h01) begin
                nxt_core.div_cnt = 8'h00;
                nxt_core.sclk = ~core_ff.sclk;
            end else begin
                nxt_core.div_cnt = core_ff.div_cnt + 8'h01;
            end
        end else begin
            nxt_core.div_cnt = 8'h00;
            nxt_core.sclk = 1'b0;
        end
        nxt_core.sclk_oe = en_i & int_sel[1];
        nxt_core.st = core_ff.st & ~err_clr_i;
        if (err_evt) begin
            nxt_core.st.fs_err = 1'b1;
        end
        for (int i = 0; i < LINES; i++) begin
            cmp_in[i] = txm[i] ? fifo_out_data[i] : link_ff.rx_hold[i];
            fifo_in_valid[i] = txm[i] ? dma_tx_valid_i[i] : (word_evt & link_ff.ev_rx);
            fifo_in_data[i] = txm[i] ? dma_tx_data_i[i] : cmp_out[i];
            fifo_out_ready[i] = txm[i] ? (~core_ff.tx_full[i] & ~word_evt) : dma_rx_ready_i[i];
            if (!txm[i] && word_evt && link_ff.ev_rx && !fifo_in_ready[i]) begin
                nxt_core.st.overrun[i] = 1'b1;
            end
            if (txm[i] && fifo_out_valid[i] && fifo_out_ready[i]) begin
                nxt_core.tx_hold[i] = cmp_out[i];
                nxt_core.tx_full[i] = 1'b1;
            end
            if (txm[i] && word_evt && link_ff.ev_tx) begin
                if (!core_ff.tx_full[i]) begin
                    nxt_core.st.underrun[i] = 1'b1;
                end
                nxt_core.tx_full[i] = 1'b0;
            end
        end
        nxt_core.irq = |nxt_core.st;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            core_ff <= '0;
        end else begin
            core_ff <= nxt_core;
        end
    end

    assign status_o = core_ff.st;
    assign err_irq_o = core_ff.irq | err_chain_i;
    assign sclk_o = core_ff.sclk;
    assign sclk_oe_o = core_ff.sclk_oe;
    assign dma_tx_ready_o = txm & fifo_in_ready;
    assign dma_rx_valid_o = ~txm & fifo_out_valid;
    assign dma_rx_data_o = fifo_out_data;

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------
    assign fs_now = link_ff.cfg.int_fs ? link_ff.fs_gen : link_ff.fs_pin;
    assign pulse_mode = (link_ff.cfg.mode == FRM_STD) || (link_ff.cfg.mode == FRM_TDM);
    assign delay_mode = (link_ff.cfg.mode == FRM_I2S) || (link_ff.cfg.mode == FRM_PI2S);
    // Level modes start a word on either fs edge, one per level
    assign start_evt = link_ff.on & (pulse_mode ? (fs_now & ~link_ff.fs_d) :
                                                  (fs_now ^ link_ff.fs_d));
    assign start = delay_mode ? link_ff.pend : start_evt;
    assign last = link_ff.busy && (link_ff.idx == 6'(link_ff.cfg.word_len - 6'h01));
    assign cont = last && (link_ff.left != 7'h00);

    always_comb begin
        nxt_link = link_ff;
        ev_rx = 1'b0;
        ev_tx = 1'b0;
        nxt_link.en_s = {link_ff.en_s[1:0], en_i};
        if (link_ff.en_s[1] == link_ff.en_s[2]) begin
            nxt_link.on = link_ff.en_s[2];
        end
        nxt_link.fs_pin = pin_in_i.fs;
        nxt_link.fs_d = fs_now;
        nxt_link.pend = delay_mode & start_evt;
        if (link_ff.on && link_ff.cfg.int_fs) begin
            nxt_link.fcnt = (link_ff.fcnt >= link_ff.cfg.frame_bits - 12'h001) ? 12'h000 :
                            link_ff.fcnt + 12'h001;
        end else begin
            nxt_link.fcnt = 12'h000;
        end
        nxt_link.fs_gen = link_ff.on & link_ff.cfg.int_fs &
                          (pulse_mode ? (nxt_link.fcnt == 12'h000) :
                           ((nxt_link.fcnt < (link_ff.cfg.frame_bits >> 1)) ^
                            (link_ff.cfg.mode == FRM_I2S)));
        // Both lines shift together; audio modes thus carry two stereo pairs
        for (int i = 0; i < LINES; i++) begin
            if (link_ff.busy) begin
                nxt_link.rx_sh[i][bit_pos(link_ff.idx, link_ff.cfg.word_len,
                                          link_ff.cfg.msb_first)] = pin_in_i.dat[i];
            end
        end
        if (last) begin
            nxt_link.rx_hold = nxt_link.rx_sh;
            ev_rx = 1'b1;
        end
        if (start && link_ff.busy && !last) begin
            nxt_link.err_tgl = ~link_ff.err_tgl;
        end
        if (start || cont) begin
            nxt_link.busy = 1'b1;
            nxt_link.idx = 6'h00;
            nxt_link.left = start ? (pulse_mode || delay_mode ?
                            ((link_ff.cfg.mode == FRM_TDM || link_ff.cfg.mode == FRM_PI2S) ?
                             link_ff.cfg.slots_m1 : 7'h00) : 7'h00) :
                            link_ff.left - 7'h01;
            nxt_link.tx_sh = core_ff.tx_hold;
            nxt_link.rx_sh = '0;
            ev_tx = 1'b1;
        end else if (link_ff.busy) begin
            nxt_link.busy = ~last;
            nxt_link.idx = link_ff.idx + 6'h01;
        end
        if (!link_ff.on) begin
            nxt_link.busy = 1'b0;
            nxt_link.pend = 1'b0;
            nxt_link.left = 7'h00;
            nxt_link.cfg = cfg_i;
            nxt_link.cfg.word_len = eff_len(cfg_i);
            nxt_link.cfg.line_tx = eff_tx(cfg_i);
            {nxt_link.cfg.int_clk, nxt_link.cfg.int_fs} = eff_int(cfg_i);
        end
        for (int i = 0; i < LINES; i++) begin
            nxt_link.dout[i] = nxt_link.busy &
                               nxt_link.tx_sh[i][bit_pos(nxt_link.idx, nxt_link.cfg.word_len,
                                                         nxt_link.cfg.msb_first)];
        end
        if (ev_rx || ev_tx) begin
            nxt_link.word_tgl = ~link_ff.word_tgl;
            nxt_link.ev_rx = ev_rx;
            nxt_link.ev_tx = ev_tx;
        end
    end

    always_ff @(posedge sclk_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            link_ff <= '0;
        end else begin
            link_ff <= nxt_link;
        end
    end

    assign pin_out_o.fs = link_ff.fs_gen;
    assign pin_oe_o.fs = link_ff.on & link_ff.cfg.int_fs;
    assign pin_out_o.dat = link_ff.dout;
    assign pin_oe_o.dat = {2{link_ff.on}} & link_ff.cfg.line_tx;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sclk_half: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        ($changed(sclk_o) && en_i && $stable(cfg_i)) |=> $stable(sclk_o))
        else $error("generated bit clock faster than a quarter of core");

    a_err_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (status_o.fs_err && !err_clr_i.fs_err) |=> status_o.fs_err)
        else $error("fs error bit dropped without a clear");

    a_err_set_wins: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        err_evt |=> status_o.fs_err)
        else $error("fs error event lost");

    a_irq_merge: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (status_o != '0 || err_chain_i) |-> err_irq_o)
        else $error("error interrupt missing");

    a_ext_clk_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        !en_i |=> (!sclk_oe_o && !sclk_o))
        else $error("bit clock driven while disabled");

    a_len_floor: assert property (@(posedge sclk_clk_i) disable iff (!rst_b_i)
        link_ff.on |-> (link_ff.cfg.word_len >= LEN_MIN_STD && link_ff.cfg.word_len <= LEN_MAX &&
        ((link_ff.cfg.mode != FRM_I2S && link_ff.cfg.mode != FRM_LJ) ||
         link_ff.cfg.word_len >= LEN_MIN_AUD)))
        else $error("word length outside its range");

    a_early_fs: assert property (@(posedge sclk_clk_i) disable iff (!rst_b_i)
        (start && link_ff.busy && !last) |=> $changed(link_ff.err_tgl))
        else $error("early frame sync not flagged");

    a_slot_bound: assert property (@(posedge sclk_clk_i) disable iff (!rst_b_i)
        link_ff.left <= link_ff.cfg.slots_m1)
        else $error("slot count beyond the frame size");

    a_pair_rx: assert property (@(posedge sclk_clk_i) disable iff (!rst_b_i)
        (link_ff.on && link_ff.cfg.pair_en && link_ff.cfg.pair_rx) |->
        (pin_oe_o.dat == 2'h0 && !pin_oe_o.fs))
        else $error("receiving partner drives a pin");
endmodule
`default_nettype wire

// File: codec_model.sv
// Far-side codec model: makes frame sync, sends one word and captures one.
// Assumes the bench supplies the bit clock; data changes after our edge.
`timescale 1ns/1ns
`default_nettype none
module codec_model (
    input wire logic sclk_i,
    input wire logic rst_b_i,
    input wire logic fire_i,
    input wire logic [7:0] period_i,
    input wire logic [5:0] len_i,
    input wire logic [31:0] word_i,
    input wire logic dat_i,
    output logic fs_o,
    output logic dat_o,
    output logic [31:0] word_o
);
    // ---------------------------------------
    // Frame timing, counted in link edges
    // ---------------------------------------
    logic [7:0] cnt;
    always @(posedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= 8'hff;
            fs_o <= 1'b0;
            dat_o <= 1'b0;
            word_o <= 32'h0;
        end else begin
            fs_o <= fire_i && !fs_o && cnt >= period_i - 8'h01;
            cnt <= fs_o ? 8'h01 : (cnt == 8'hff ? cnt : cnt + 8'h01);
            // First bit follows the port's start edge, so it is sampled one edge on
            if (cnt >= 8'h01 && cnt <= {2'h0, len_i}) begin
                dat_o <= word_i[int'(len_i) - int'(cnt)];
            end else begin
                // Outside a word the line wanders, never a held value
                dat_o <= ~dat_o;
            end
            if (fs_o) begin
                word_o <= 32'h0;
            end else if (cnt >= 8'h02 && cnt <= {2'h0, len_i} + 8'h01) begin
                word_o <= {word_o[30:0], dat_i};
            end
        end
    end
endmodule
`default_nettype wire

// File: sync_serial_port_bench.sv
// Self-checking bench for one port: standard words both ways, buffer refusal,
// early frame sync error and the shared error line.
// Assumes an external bit clock at a quarter of the core rate.
`timescale 1ns/1ns
`default_nettype none
module sync_serial_port_bench;
    import sync_serial_port_pkg::*;
    typedef struct packed {logic msb; logic [5:0] len; logic [31:0] tx; logic [31:0] rx;} row_t;
    localparam int DLY = 2;
    logic core_clk = 1'b0, sclk = 1'b0, rst_b = 1'b0, en = 1'b0, chain = 1'b0, fire = 1'b0;
    logic irq, sclk_o, sclk_oe, pfs, pdat, ok;
    cfg_t cfg;
    status_t clr, status;
    pins_t pin_in, pin_out, pin_oe;
    logic [1:0] txv, txr, rxv, rxr;
    logic [1:0][31:0] txd, rxd;
    logic [7:0] period;
    logic [5:0] len;
    logic [31:0] pword, mword, d;
    int num_errors = 0, compares = 0, n;
    row_t rows [4] = '{'{1'b1, 6'h08, 32'h000000a5, 32'h0000003c},
        '{1'b0, 6'h08, 32'h000000a5, 32'h000000c1}, '{1'b1, 6'h03, 32'h00000005, 32'h00000006},
        '{1'b0, 6'h20, 32'h12345678, 32'h89abcdef}};
    always #20 core_clk = ~core_clk;
    // Bit clock at exactly a quarter of the core rate, the fastest allowed
    always #80 sclk = ~sclk;
    assign pin_in = {pfs, pdat, pin_out.dat[0]};
    sync_serial_port uut (.core_clk_i(core_clk), .rst_b_i(rst_b), .sclk_clk_i(sclk), .en_i(en),
        .cfg_i(cfg), .err_clr_i(clr), .err_chain_i(chain), .status_o(status), .err_irq_o(irq),
        .sclk_o(sclk_o), .sclk_oe_o(sclk_oe), .pin_in_i(pin_in), .pin_out_o(pin_out),
        .pin_oe_o(pin_oe), .dma_tx_valid_i(txv), .dma_tx_ready_o(txr), .dma_tx_data_i(txd),
        .dma_rx_valid_o(rxv), .dma_rx_ready_i(rxr), .dma_rx_data_o(rxd));
    codec_model far (.sclk_i(sclk), .rst_b_i(rst_b), .fire_i(fire), .period_i(period),
        .len_i(len), .word_i(pword), .dat_i(pin_out.dat[0]), .fs_o(pfs), .dat_o(pdat),
        .word_o(mword));
    // ---------------------------------------
    // Helpers
    // ---------------------------------------
    function automatic logic [31:0] order(input logic [31:0] w, input int k, input logic msb);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < k; i++) begin
            r[i] = msb ? w[i] : w[k-1-i];
        end
        return r;
    endfunction
    task print_verdict;
        $display("checks %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task bail(input logic hit);
        if (hit) begin
            check("wait", 32'h0, 32'h1);
            print_verdict;
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge core_clk);
        #DLY;
    endtask
    // ---------------------------------------
    // Main sequence
    // ---------------------------------------
    initial begin
        cfg = '0;
        clr = '0;
        txv = 2'h0;
        txd = '0;
        rxr = 2'h0;
        period = 8'h14;
        len = 6'h08;
        pword = 32'h0;
        cfg.mode = FRM_STD;
        cfg.clk_half = HALF_DIV_MIN;
        cfg.line_tx = 2'b01;
        cyc(6);
        rst_b = 1'b1;
        check("status", status, 32'h0);
        check("irq", irq, 32'h0);
        check("rx valid", rxv, 32'h0);
        foreach (rows[r]) begin
            en = 1'b0;
            cfg.msb_first = rows[r].msb;
            cfg.word_len = rows[r].len;
            len = rows[r].len;
            period = {2'h0, rows[r].len} + 8'h04;
            pword = rows[r].rx;
            cyc(20);
            txd[0] = rows[r].tx;
            txv[0] = 1'b1;
            ok = 1'b0;
            for (n = 0; n < 4 && !ok; n++) begin
                ok = (txr[0] === 1'b1);
                cyc(1);
            end
            txv[0] = 1'b0;
            check("tx taken", ok, 32'h1);
            en = 1'b1;
            cyc(20);
            check("pin enables", pin_oe, 32'h1);
            check("clock enable", sclk_oe, 32'h0);
            fire = 1'b1;
            for (n = 0; n < 100 && pfs !== 1'b1; n++) cyc(1);
            fire = 1'b0;
            bail(n == 100);
            for (n = 0; n < 600 && rxv[1] !== 1'b1; n++) cyc(1);
            bail(n == 600);
            d = rxd[1];
            rxr[1] = 1'b1;
            cyc(1);
            rxr[1] = 1'b0;
            check("rx word", d, order(rows[r].rx, rows[r].len, rows[r].msb));
            check("wire word", mword, order(rows[r].tx, rows[r].len, rows[r].msb));
            check("status", status, 32'h0);
        end
        en = 1'b0;
        cyc(20);
        txv[0] = 1'b1;
        for (n = 0; n < 24 && txr[0] === 1'b1; n++) cyc(1);
        txv[0] = 1'b0;
        check("fifo fill", n >= FIFO_DEPTH && n <= FIFO_DEPTH + 1, 32'h1);
        check("rx line refuses", txr[1], 32'h0);
        // Frame every 8 bits while words are 16 long
        len = 6'h10;
        cfg.word_len = 6'h10;
        period = 8'h08;
        cyc(20);
        en = 1'b1;
        cyc(20);
        fire = 1'b1;
        cyc(200);
        fire = 1'b0;
        cyc(20);
        check("fs error", status.fs_err, 32'h1);
        check("irq", irq, 32'h1);
        cyc(100);
        check("fs error held", status.fs_err, 32'h1);
        clr = '1;
        cyc(1);
        clr = '0;
        cyc(3);
        check("status cleared", status, 32'h0);
        check("irq", irq, 32'h0);
        chain = 1'b1;
        cyc(1);
        check("irq chained", irq, 32'h1);
        // Internal clock with a too small divider must clamp to a quarter rate
        en = 1'b0;
        cfg.int_clk = 1'b1;
        cfg.clk_half = 8'h01;
        cyc(20);
        en = 1'b1;
        cyc(4);
        check("clock driven", sclk_oe, 32'h1);
        n = 0;
        for (int i = 0; i < 16; i++) begin
            d[0] = sclk_o;
            cyc(1);
            n += (sclk_o != d[0]);
        end
        check("clock toggles", n, 32'(16 / HALF_DIV_MIN));
        print_verdict;
    end
endmodule
`default_nettype wire
